// [tcrb_pin_model.sv]
// Far-side model: count and trigger pins, timer 1 overflow and the
// second port clock selects. Assumes one sys_clk shared with the timer.
module tcrb_pin_model (
  input wire logic sys_clk,
  output logic countPin,
  output logic triggerPin,
  output logic timer1Overflow,
  output logic secondPortRxClockSelect,
  output logic secondPortTxClockSelect
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Idle levels: port pins rest high on their pull-ups
  initial begin
    countPin = 1'b1;
    triggerPin = 1'b1;
    timer1Overflow = 1'b0;
    secondPortRxClockSelect = 1'b0;
    secondPortTxClockSelect = 1'b0;
  end

  // ==========================================================
  // Held low thirty clocks, two and a half machine cycles
  // Shorter pulses may fall between samples and be lost
  task automatic pin_fall(input logic onCount);
    @(posedge sys_clk);
    if (onCount) countPin <= 1'b0;
    else triggerPin <= 1'b0;
    repeat (30) @(posedge sys_clk);
    countPin <= 1'b1;
    triggerPin <= 1'b1;
    repeat (30) @(posedge sys_clk);
  endtask : pin_fall

  task automatic t1_pulse();
    @(posedge sys_clk);
    timer1Overflow <= 1'b1;
    @(posedge sys_clk);
    timer1Overflow <= 1'b0;
  endtask : t1_pulse

  task automatic set_second(input logic rx, input logic tx);
    @(posedge sys_clk);
    secondPortRxClockSelect <= rx;
    secondPortTxClockSelect <= tx;
  endtask : set_second
endmodule : tcrb_pin_model

// [tcrb_pkg.sv]
// Constants and types for the third timer/counter with capture and reload.
// Assumes a CPU that reaches the block through a byte-wide register port.
package tcrb_pkg;

  // ==========================================================
  // Register port addresses
  localparam logic [2:0] TCRB_ADDR_CONTROL = 3'h0;
  localparam logic [2:0] TCRB_ADDR_COUNT_LOW = 3'h1;
  localparam logic [2:0] TCRB_ADDR_COUNT_HIGH = 3'h2;
  localparam logic [2:0] TCRB_ADDR_CAPTURE_LOW = 3'h3;
  localparam logic [2:0] TCRB_ADDR_CAPTURE_HIGH = 3'h4;

  // ==========================================================
  // Control bit positions
  localparam int TCRB_BIT_OVERFLOW = 7;
  localparam int TCRB_BIT_EXTERNAL = 6;
  localparam int TCRB_BIT_RX_SEL = 5;
  localparam int TCRB_BIT_TX_SEL = 4;
  localparam int TCRB_BIT_EXT_EN = 3;
  localparam int TCRB_BIT_RUN = 2;
  localparam int TCRB_BIT_COUNTER = 1;
  localparam int TCRB_BIT_CAPTURE = 0;

  // ==========================================================
  // Reset values and timing
  localparam logic [7:0] TCRB_CONTROL_RESET = 8'h00;
  localparam logic [15:0] TCRB_COUNT_RESET = 16'h0000;
  localparam logic [15:0] TCRB_CAPTURE_RESET = 16'h0000;
  localparam logic [15:0] TCRB_COUNT_MAX = 16'hFFFF;
  // One machine cycle is twelve oscillator periods
  localparam int TCRB_MACHINE_CLOCKS = 12;
  localparam logic [3:0] TCRB_PRESCALE_LAST = 4'(TCRB_MACHINE_CLOCKS - 1);

  // ==========================================================
  // Carried types
  typedef struct packed {
    logic overflowFlag;
    logic externalEventFlag;
    logic rxClockSelect;
    logic txClockSelect;
    logic externalEnable;
    logic runControl;
    logic counterSelect;
    logic captureReloadSelect;
  } tcrb_ctrl_t;

  typedef struct packed {
    logic port1Rx;
    logic port1Tx;
    logic port2Rx;
    logic port2Tx;
  } tcrb_baud_t;

endpackage : tcrb_pkg

// [tcrb_timer2.sv]
// Third 16-bit timer/counter: capture, auto-reload and baud clock modes.
// Assumes count and trigger pins arrive asynchronously, the register port
// and timer 1 overflow run on sys_clk, and sys_clk is the oscillator.

module tcrb_timer2
  import tcrb_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [2:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrRead,
  output logic [7:0] sfrRdata,
  input wire logic countPin,
  input wire logic triggerPin,
  input wire logic timer1Overflow,
  input wire logic secondPortRxClockSelect,
  input wire logic secondPortTxClockSelect,
  output logic timerIrq,
  output logic overflowPulse,
  output tcrb_baud_t baudTick
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] pickByte(input logic [15:0] word,
                                          input logic high);
    pickByte = high ? word[15:8] : word[7:0];
  endfunction : pickByte

  function automatic logic fell(input logic prev, input logic now);
    fell = prev & ~now;
  endfunction : fell

  // ==========================================================
  // State
  tcrb_ctrl_t ctrl_q, ctrl_d;
  logic [15:0] count_q, count_d;
  logic [15:0] capture_q, capture_d;
  logic [3:0] prescale_q;
  logic machineTick_q;
  logic [1:0] countSync_q, trigSync_q;
  logic countSample_q, trigSample_q;
  logic countPrev_q, trigPrev_q;
  logic [7:0] rdata_q;
  logic irq_q, ovfPulse_q;
  tcrb_baud_t baud_q, baud_d;

  // ==========================================================
  // Decode
  wire ctrlWr = sfrWrite && (sfrAddr == TCRB_ADDR_CONTROL);
  wire cntLoWr = sfrWrite && (sfrAddr == TCRB_ADDR_COUNT_LOW);
  wire cntHiWr = sfrWrite && (sfrAddr == TCRB_ADDR_COUNT_HIGH);
  wire capLoWr = sfrWrite && (sfrAddr == TCRB_ADDR_CAPTURE_LOW);
  wire capHiWr = sfrWrite && (sfrAddr == TCRB_ADDR_CAPTURE_HIGH);
  wire countWr = cntLoWr || cntHiWr;

  // Either port clocked from this timer means baud mode
  wire baudMode = ctrl_q.rxClockSelect || ctrl_q.txClockSelect ||
                  secondPortRxClockSelect || secondPortTxClockSelect;
  // Capture bit honoured only outside baud mode
  wire captureMode = ctrl_q.captureReloadSelect && !baudMode;

  // Edges seen by comparing successive machine-cycle samples
  wire countFall = machineTick_q && fell(countPrev_q, countSample_q);
  wire trigFall = machineTick_q && fell(trigPrev_q, trigSample_q);

  // Source choice: machine cycle or count-pin fall
  wire countStep = ctrl_q.counterSelect ? countFall : machineTick_q;
  wire countEvt = ctrl_q.runControl && countStep;
  wire overflowEvt = countEvt && (count_q == TCRB_COUNT_MAX);
  // Trigger events only with the external enable set
  wire trigEvt = ctrl_q.externalEnable && trigFall;
  wire captureEvt = trigEvt && captureMode;
  // Trigger reload only in plain reload mode
  wire trigReload = trigEvt && !captureMode && !baudMode;
  // Rollover reloads in reload and baud modes
  wire ovfReload = overflowEvt && !captureMode;
  wire reloadEvt = ovfReload || trigReload;
  // Overflow flag never set in baud mode
  wire ovfFlagSet = overflowEvt && !baudMode;
  // External flag from any enabled trigger fall
  wire extFlagSet = trigEvt;

  wire [7:0] readMux =
    (sfrAddr == TCRB_ADDR_CONTROL) ? ctrl_q :
    (sfrAddr == TCRB_ADDR_COUNT_LOW) ? pickByte(count_q, 1'b0) :
    (sfrAddr == TCRB_ADDR_COUNT_HIGH) ? pickByte(count_q, 1'b1) :
    (sfrAddr == TCRB_ADDR_CAPTURE_LOW) ? pickByte(capture_q, 1'b0) :
    (sfrAddr == TCRB_ADDR_CAPTURE_HIGH) ? pickByte(capture_q, 1'b1) :
    8'h00;

  // ==========================================================
  // Next-state logic
  always_comb begin
    ctrl_d = ctrlWr ? tcrb_ctrl_t'(sfrWdata) : ctrl_q;
    // Hardware set wins over a software clear
    ctrl_d.overflowFlag = ctrl_d.overflowFlag | ovfFlagSet;
    ctrl_d.externalEventFlag = ctrl_d.externalEventFlag | extFlagSet;
  end

  always_comb begin
    count_d = count_q;
    if (reloadEvt) begin
      count_d = capture_q;
    end else if (countEvt) begin
      // Up only, wraps to zero in capture mode
      count_d = count_q + 16'h0001;
    end
    // Software write to a count byte beats the hardware update
    if (cntLoWr) begin
      count_d[7:0] = sfrWdata;
    end
    if (cntHiWr) begin
      count_d[15:8] = sfrWdata;
    end
  end

  always_comb begin
    capture_d = capture_q;
    if (captureEvt) begin
      capture_d = count_q;
    end
    if (capLoWr) begin
      capture_d[7:0] = sfrWdata;
    end
    if (capHiWr) begin
      capture_d[15:8] = sfrWdata;
    end
  end

  // Port one clocks; timer 1 overflow when unselected
  // Port two selects come from the power-control pair
  always_comb begin
    baud_d.port1Rx = ctrl_q.rxClockSelect ? overflowEvt : timer1Overflow;
    baud_d.port1Tx = ctrl_q.txClockSelect ? overflowEvt : timer1Overflow;
    baud_d.port2Rx = secondPortRxClockSelect ? overflowEvt
                                             : timer1Overflow;
    baud_d.port2Tx = secondPortTxClockSelect ? overflowEvt
                                             : timer1Overflow;
  end

  // ==========================================================
  // Machine-cycle prescaler
  // One tick every twelve oscillator clocks
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prescale_q <= 4'h0;
      machineTick_q <= 1'b0;
    end else begin
      prescale_q <= (prescale_q == TCRB_PRESCALE_LAST) ? 4'h0
                                                       : prescale_q + 4'h1;
      machineTick_q <= (prescale_q == TCRB_PRESCALE_LAST);
    end
  end

  // ==========================================================
  // Pin synchronisers and machine-cycle samples
  // Pins are asynchronous, so two flops come before any edge logic
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      countSync_q <= 2'h3;
      trigSync_q <= 2'h3;
    end else begin
      countSync_q <= {countSync_q[0], countPin};
      trigSync_q <= {trigSync_q[0], triggerPin};
    end
  end

  // Sample once per machine cycle, keep previous sample
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      countSample_q <= 1'b1;
      trigSample_q <= 1'b1;
      countPrev_q <= 1'b1;
      trigPrev_q <= 1'b1;
    end else if (prescale_q == TCRB_PRESCALE_LAST) begin
      countSample_q <= countSync_q[1];
      trigSample_q <= trigSync_q[1];
      countPrev_q <= countSample_q;
      trigPrev_q <= trigSample_q;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_q <= tcrb_ctrl_t'(TCRB_CONTROL_RESET);
      count_q <= TCRB_COUNT_RESET;
      capture_q <= TCRB_CAPTURE_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      capture_q <= capture_d;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      ovfPulse_q <= 1'b0;
      baud_q <= '0;
    end else begin
      rdata_q <= sfrRead ? readMux : 8'h00;
      // Either sticky flag requests the timer interrupt
      irq_q <= ctrl_d.overflowFlag || ctrl_d.externalEventFlag;
      ovfPulse_q <= overflowEvt;
      baud_q <= baud_d;
    end
  end

  assign sfrRdata = rdata_q;
  assign timerIrq = irq_q;
  assign overflowPulse = ovfPulse_q;
  assign baudTick = baud_q;

  // ==========================================================
  // Checks
  sequence quietEleven;
    !machineTick_q [*8] ##1 !machineTick_q ##1 !machineTick_q
      ##1 !machineTick_q;
  endsequence

  sequence tickAgain;
    ##1 machineTick_q;
  endsequence

  chk_tick_period_twelve: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    machineTick_q |=> quietEleven ##0 tickAgain)
    else $error("Machine tick period is not twelve clocks");

  chk_run_stop_hold: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !ctrl_q.runControl && !countWr && !trigReload |=> $stable(count_q))
    else $error("Count moved while stopped");

  chk_internal_count_step: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ctrl_q.runControl && !ctrl_q.counterSelect && machineTick_q &&
      count_q != TCRB_COUNT_MAX && !countWr && !reloadEvt
    |=> count_q == $past(count_q) + 16'h0001)
    else $error("Internal count did not step");

  chk_capture_copy_value: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    captureEvt && !capLoWr && !capHiWr
    |=> capture_q == $past(count_q) && ctrl_q.externalEventFlag)
    else $error("Capture did not copy count");

  chk_reload_on_rollover: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    overflowEvt && !ctrl_q.captureReloadSelect && !baudMode && !countWr
    |=> count_q == $past(capture_q) && ctrl_q.overflowFlag)
    else $error("Rollover reload or flag missing");

  chk_capture_wraps_zero: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    overflowEvt && captureMode && !countWr
    |=> count_q == 16'h0000 && ctrl_q.overflowFlag)
    else $error("Capture mode overflow wrong");

  chk_ovf_flag_cause: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(ctrl_q.overflowFlag)
    |-> $past(ctrlWr) || ($past(overflowEvt) && !$past(baudMode)))
    else $error("Overflow flag set without cause");

  chk_ext_flag_cause: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(ctrl_q.externalEventFlag)
    |-> $past(ctrlWr) || ($past(trigFall) && $past(ctrl_q.externalEnable)))
    else $error("External flag set without enabled trigger");

  chk_baud_trigger_only: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    trigEvt && baudMode && !overflowEvt && !countEvt && !countWr
    |=> $stable(count_q) && ctrl_q.externalEventFlag)
    else $error("Baud mode trigger touched the count");

  chk_port1_rx_route: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    ctrl_q.rxClockSelect && overflowEvt |=> baudTick.port1Rx)
    else $error("Port one receive clock not routed");

  chk_port2_tx_route: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !secondPortTxClockSelect |=> baudTick.port2Tx == $past(timer1Overflow))
    else $error("Port two transmit clock not from timer 1");

endmodule : tcrb_timer2

// [tcrb_timer2_tb.sv]
// Self-checking bench for the third timer: registers, pins, baud ticks.
// Assumes the pin model as far side and a 250 MHz sys_clk.
module tcrb_timer2_tb
  import tcrb_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk, sys_rst, sfrWrite, sfrRead, timerIrq, overflowPulse;
  logic [2:0] sfrAddr;
  logic [7:0] sfrWdata, sfrRdata, b;
  logic countPin, triggerPin, timer1Overflow, rx2Sel, tx2Sel, ovSeen;
  logic [15:0] v, w;
  tcrb_baud_t baudTick, tickSeen;
  int fails, checkCount, waited;

  tcrb_timer2 tcrb_timer2_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWdata(sfrWdata),
    .sfrRead(sfrRead), .sfrRdata(sfrRdata), .countPin(countPin),
    .triggerPin(triggerPin), .timer1Overflow(timer1Overflow),
    .secondPortRxClockSelect(rx2Sel), .secondPortTxClockSelect(tx2Sel),
    .timerIrq(timerIrq), .overflowPulse(overflowPulse),
    .baudTick(baudTick));
  tcrb_pin_model tcrb_pin_model_i (.sys_clk(sys_clk), .countPin(countPin),
    .triggerPin(triggerPin), .timer1Overflow(timer1Overflow),
    .secondPortRxClockSelect(rx2Sel), .secondPortTxClockSelect(tx2Sel));

  // ==========================================================
  // Shared tasks
  task automatic check_val(input logic [15:0] seen, input logic [15:0] exp);
    checkCount++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check_val

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrWrite <= 1'b1;
    sfrWdata <= d;
    @(posedge sys_clk);
    sfrWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    sfrAddr <= a;
    sfrRead <= 1'b1;
    @(posedge sys_clk);
    sfrRead <= 1'b0;
    #1 d = sfrRdata;
  endtask : rd

  task automatic wr16(input logic [2:0] a, input logic [15:0] d);
    wr(a, d[7:0]);
    wr(3'(a + 3'h1), d[15:8]);
  endtask : wr16

  task automatic rd16(input logic [2:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(3'(a + 3'h1), d[15:8]);
  endtask : rd16

  // Stops at the first overflow pulse so the count is read before it moves
  task automatic catch_ov(input int n);
    tickSeen = '0;
    ovSeen = 1'b0;
    for (waited = 0; waited < n && !ovSeen; waited++) begin
      @(posedge sys_clk);
      #1 tickSeen = tickSeen | baudTick;
      ovSeen = overflowPulse;
    end
  endtask : catch_ov

  // ==========================================================
  // Scenarios
  task automatic sc_reset_values();
    rd(TCRB_ADDR_CONTROL, b);
    check_val(16'(b), 16'(TCRB_CONTROL_RESET));
    rd16(TCRB_ADDR_COUNT_LOW, v);
    check_val(v, TCRB_COUNT_RESET);
    rd16(TCRB_ADDR_CAPTURE_LOW, v);
    check_val(v, TCRB_CAPTURE_RESET);
    rd(3'h7, b);
    check_val(16'(b), 16'h0000);
  endtask : sc_reset_values

  task automatic sc_plain_overflow();
    wr(TCRB_ADDR_CONTROL, 8'h01);
    wr16(TCRB_ADDR_COUNT_LOW, 16'hFFFE);
    wr(TCRB_ADDR_CONTROL, 8'h05);
    catch_ov(60);
    check_val(16'(waited >= 12 && waited <= 28), 16'h0001);
    check_val(16'(timerIrq), 16'h0001);
    rd16(TCRB_ADDR_COUNT_LOW, v);
    check_val(v, 16'h0000);
    rd(TCRB_ADDR_CONTROL, b);
    check_val(16'(b), 16'h0085);
    wr(TCRB_ADDR_CONTROL, 8'h01);
    rd16(TCRB_ADDR_COUNT_LOW, v);
    repeat (40) @(posedge sys_clk);
    rd16(TCRB_ADDR_COUNT_LOW, w);
    check_val(w, v);
    check_val(16'(timerIrq), 16'h0000);
  endtask : sc_plain_overflow

  task automatic sc_capture();
    wr(TCRB_ADDR_CONTROL, 8'h00);
    wr16(TCRB_ADDR_COUNT_LOW, 16'h1234);
    wr(TCRB_ADDR_CONTROL, 8'h0F);
    tcrb_pin_model_i.pin_fall(1'b0);
    rd16(TCRB_ADDR_CAPTURE_LOW, v);
    check_val(v, 16'h1234);
    rd(TCRB_ADDR_CONTROL, b);
    check_val(16'(b), 16'h004F);
    check_val(16'(timerIrq), 16'h0001);
    tcrb_pin_model_i.pin_fall(1'b1);
    rd16(TCRB_ADDR_COUNT_LOW, v);
    check_val(v, 16'h1235);
    wr(TCRB_ADDR_CONTROL, 8'h07);
    tcrb_pin_model_i.pin_fall(1'b0);
    rd(TCRB_ADDR_CONTROL, b);
    check_val(16'(b), 16'h0007);
    rd16(TCRB_ADDR_CAPTURE_LOW, v);
    check_val(v, 16'h1234);
  endtask : sc_capture

  task automatic sc_reload();
    wr16(TCRB_ADDR_CAPTURE_LOW, 16'h5678);
    wr(TCRB_ADDR_CONTROL, 8'h0E);
    tcrb_pin_model_i.pin_fall(1'b0);
    rd16(TCRB_ADDR_COUNT_LOW, v);
    check_val(v, 16'h5678);
    wr16(TCRB_ADDR_COUNT_LOW, 16'hFFFF);
    tcrb_pin_model_i.pin_fall(1'b1);
    rd16(TCRB_ADDR_COUNT_LOW, v);
    check_val(v, 16'h5678);
    rd(TCRB_ADDR_CONTROL, b);
    check_val(16'(b), 16'h00CE);
  endtask : sc_reload

  task automatic sc_baud();
    wr(TCRB_ADDR_CONTROL, 8'h00);
    wr16(TCRB_ADDR_CAPTURE_LOW, 16'hFFFE);
    wr16(TCRB_ADDR_COUNT_LOW, 16'hFFFE);
    wr(TCRB_ADDR_CONTROL, 8'h3D);
    catch_ov(60);
    check_val(16'(tickSeen), 16'h000C);
    rd(TCRB_ADDR_COUNT_HIGH, b);
    check_val(16'(b), 16'h00FF);
    rd(TCRB_ADDR_CONTROL, b);
    check_val(16'(b), 16'h003D);
    // Idle count pin, so the trigger fall is not paired with a count step
    wr(TCRB_ADDR_CONTROL, 8'h3F);
    tcrb_pin_model_i.pin_fall(1'b0);
    rd(TCRB_ADDR_CONTROL, b);
    check_val(16'(b), 16'h007F);
    // Second port selects first, so no overflow meets plain reload mode
    tcrb_pin_model_i.set_second(1'b1, 1'b1);
    wr(TCRB_ADDR_CONTROL, 8'h04);
    catch_ov(60);
    check_val(16'(tickSeen), 16'h0003);
    rd(TCRB_ADDR_CONTROL, b);
    check_val(16'(b), 16'h0004);
    tcrb_pin_model_i.set_second(1'b0, 1'b0);
    tcrb_pin_model_i.t1_pulse();
    #1 check_val(16'(baudTick), 16'h000F);
  endtask : sc_baud

  // ==========================================================
  // Clock, verdict, watchdog and main sequence
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  // Whole run needs about 600 cycles; over thirty times that means a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    complete_run();
  end

  initial begin
    sys_rst <= 1'b1;
    sfrAddr <= 3'h0;
    sfrWrite <= 1'b0;
    sfrRead <= 1'b0;
    sfrWdata <= 8'h00;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    sc_reset_values();
    sc_plain_overflow();
    sc_capture();
    sc_reload();
    sc_baud();
    complete_run();
  end
endmodule : tcrb_timer2_tb
